// *** core/bss_pkg.sv ***
// Constants and types of the burner safeguard sequencer
// ---------------------------------------------------------------
// ---------------------------------------------------------------
package bss_pkg;
   localparam int unsigned CLK_HZ        = 10000000;
   localparam int unsigned TICK_CYCLES   = CLK_HZ;
   localparam logic [7:0] CYCLE_S        = 8'h78;
   localparam logic [7:0] PREPURGE_S     = 8'h3c;
   localparam logic [7:0] POSTPURGE_S    = 8'h10;
   localparam logic [7:0] INTLK_S        = 8'h0e;
   localparam logic [7:0] HIFIRE_S       = 8'h0a;
   localparam logic [7:0] LOFIRE_S       = 8'h33;
   localparam logic [7:0] LOFIRE_ALT_S   = 8'h34;
   localparam logic [7:0] PILOT_S        = 8'h0a;
   localparam logic [7:0] SPARK_S        = 8'h05;
   localparam logic [7:0] MAIN_10_S      = 8'h0a;
   localparam logic [7:0] MAIN_15_S      = 8'h0f;
   localparam logic [7:0] MAIN_30_S      = 8'h1e;
   localparam logic [7:0] FFRT_S         = 8'h03;
   localparam logic [7:0] TIME_ZERO      = 8'h00;

   typedef enum logic [6:0] {
      BSS_STANDBY  = 7'h01,
      BSS_PURGE    = 7'h02,
      BSS_PILOT    = 7'h04,
      BSS_MAIN     = 7'h08,
      BSS_RUN      = 7'h10,
      BSS_POST     = 7'h20,
      BSS_LOCKOUT  = 7'h40
   } bss_state_t;
endpackage

// *** core/bss_tick_if.sv ***
// Tick and hold signals between timer and sequencer
`timescale 1ns/10ps
interface bss_tick_if;
   logic secTick;
   logic hold;
   logic clear;
   logic [7:0] seconds;
   modport timer (output secTick, output seconds, input hold, input clear);
   modport seq   (input secTick, input seconds, output hold, output clear);
endinterface

// *** core/bss_timer.sv ***
// One second tick divider and program seconds counter
`timescale 1ns/10ps
module bss_timer #(
   parameter int unsigned TICK_CYCLES = bss_pkg::TICK_CYCLES
) (
   // Clock and reset
   input wire logic  core_clk,
   input wire logic  rst_n,
   // Sequencer side
   bss_tick_if.timer tk
);
   logic [23:0] div;
   logic [23:0] next_div;
   logic        tick;
   logic        next_tick;
   logic [7:0]  secs;
   logic [7:0]  next_secs;

   always_comb begin
      next_div  = div + 24'h000001;
      next_tick = 1'b0;
      next_secs = secs;
      if (div >= 24'(TICK_CYCLES - 1)) begin
         next_div  = 24'h000000;
         next_tick = 1'b1;
      end
      if (tk.clear) begin
         next_secs = bss_pkg::TIME_ZERO;
      end else if (tick && !tk.hold) begin
         next_secs = secs + 8'h01;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         div  <= 24'h000000;
         tick <= 1'b0;
         secs <= 8'h00;
      end else begin
         div  <= next_div;
         tick <= next_tick;
         secs <= next_secs;
      end
   end

   assign tk.secTick = tick;
   assign tk.seconds = secs;
endmodule // bss_timer

// *** core/bss_fail_filter.sv ***
// Flame loss debounce giving the flame failure response time
`timescale 1ns/10ps
module bss_fail_filter #(
   parameter logic [7:0] LIMIT_S = bss_pkg::FFRT_S
) (
   // Clock and reset
   input wire logic  core_clk,
   input wire logic  rst_n,
   // Inputs
   input wire logic  secTick,
   input wire logic  flame,
   // Result
   output logic      lost
);
   logic [7:0] cnt;
   logic [7:0] next_cnt;

   // Counting whole ticks gives 2 to 3 s, inside the 4 s limit
   always_comb begin
      next_cnt = cnt;
      if (flame) begin
         next_cnt = 8'h00;
      end else if (secTick && cnt < LIMIT_S) begin
         next_cnt = cnt + 8'h01;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 8'h00;
      end else begin
         cnt <= next_cnt;
      end
   end

   assign lost = !flame && (cnt >= LIMIT_S);
endmodule // bss_fail_filter

// *** core/bss_sequencer.sv ***
// Burner safeguard sequencer top level
`timescale 1ns/10ps
module bss_sequencer #(
   parameter int unsigned TICK_CYCLES = bss_pkg::TICK_CYCLES,
   parameter logic [7:0]  CYCLE_S     = bss_pkg::CYCLE_S,
   parameter logic [7:0]  PREPURGE_S  = bss_pkg::PREPURGE_S,
   parameter logic [7:0]  POSTPURGE_S = bss_pkg::POSTPURGE_S,
   parameter bit          ALT_LOFIRE  = 1'b0,
   parameter bit          EARLY_SPARK = 1'b0,
   parameter bit          HAS_30S     = 1'b0
) (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        rst_n,
   // Demand and manual reset
   input wire logic        startReq,
   input wire logic        manualReset,
   // Interlocks and flame
   input wire logic        preIgnOk,
   input wire logic        lockIntlkOk,
   input wire logic        highFireOk,
   input wire logic        lowFireOk,
   input wire logic        flamePresent,
   input wire logic        selfCheckFail,
   // Configuration
   input wire logic [1:0]  mainSel,
   input wire logic        directSpark,
   // Outputs
   output logic            blower,
   output logic            ignition,
   output logic            pilotValve,
   output logic            mainValve,
   output logic            fireHigh,
   output logic            fireLow,
   output logic            fireModulate,
   output logic            alarm,
   output logic            lockedOut,
   output logic [7:0]      seconds
);
   bss_tick_if tk ();

   bss_pkg::bss_state_t state;
   bss_pkg::bss_state_t next_state;
   logic [7:0] phaseBase;
   logic [7:0] next_phaseBase;
   logic [7:0] mainLen;
   logic [7:0] lofireAt;
   logic [7:0] el;
   logic       flameLost;
   logic       fault;
   logic       sparkOn;
   logic       next_blower;
   logic       next_ignition;
   logic       next_pilotValve;
   logic       next_mainValve;
   logic       next_fireHigh;
   logic       next_fireLow;
   logic       next_fireModulate;
   logic       next_alarm;
   logic       next_lockedOut;

   bss_timer #(.TICK_CYCLES(TICK_CYCLES)) uTimer (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .tk       (tk.timer)
   );

   bss_fail_filter uFilt (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .secTick  (tk.secTick),
      .flame    (flamePresent),
      .lost     (flameLost)
   );

   // ---------------------------------------------------------------
   // Phase lengths
   // ---------------------------------------------------------------
   always_comb begin
      lofireAt = ALT_LOFIRE ? bss_pkg::LOFIRE_ALT_S : bss_pkg::LOFIRE_S;
      case (mainSel)
         2'b00:   mainLen = bss_pkg::MAIN_10_S;
         2'b01:   mainLen = bss_pkg::MAIN_15_S;
         2'b10:   mainLen = HAS_30S ? bss_pkg::MAIN_30_S
                                    : bss_pkg::MAIN_15_S;
         2'b11:   mainLen = bss_pkg::MAIN_10_S;
         default: mainLen = bss_pkg::MAIN_10_S;
      endcase
      if (directSpark) begin
         mainLen = bss_pkg::MAIN_10_S;
      end
   end

   // ---------------------------------------------------------------
   // Time spent in the current phase
   // ---------------------------------------------------------------
   // Wraps safely: no phase outlasts the 8-bit program count
   always_comb begin
      el = tk.seconds - phaseBase;
   end

   // ---------------------------------------------------------------
   // Ignition window
   // ---------------------------------------------------------------
   // Early spark: spark for the first five pilot seconds only,
   // the pilot then burns alone; entry to pilot starts with spark
   always_comb begin
      sparkOn = 1'b1;
      if (EARLY_SPARK) begin
         sparkOn = (state != bss_pkg::BSS_PILOT) ||
                   (el < bss_pkg::SPARK_S);
      end
   end

   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   always_comb begin
      next_state     = state;
      next_phaseBase = phaseBase;
      fault          = 1'b0;
      tk.hold        = 1'b0;
      tk.clear       = 1'b0;
      case (state)
         bss_pkg::BSS_STANDBY: begin
            tk.clear = 1'b1;
            if (startReq && flamePresent) begin
               fault = 1'b1;
            end
            if (startReq && preIgnOk && !flamePresent) begin
               next_state     = bss_pkg::BSS_PURGE;
               next_phaseBase = bss_pkg::TIME_ZERO;
            end
         end
         bss_pkg::BSS_PURGE: begin
            if (tk.seconds == bss_pkg::HIFIRE_S && !highFireOk) begin
               tk.hold = 1'b1;
            end
            if (tk.seconds == lofireAt && !lowFireOk) begin
               tk.hold = 1'b1;
            end
            if (flamePresent) begin
               fault = 1'b1;
            end
            if (tk.seconds >= bss_pkg::INTLK_S && !preIgnOk) begin
               fault = 1'b1;
            end
            if (tk.seconds >= bss_pkg::INTLK_S && !lockIntlkOk) begin
               fault = 1'b1;
            end
            if (tk.seconds >= PREPURGE_S && lowFireOk && !tk.hold) begin
               next_state     = bss_pkg::BSS_PILOT;
               next_phaseBase = tk.seconds;
            end
         end
         bss_pkg::BSS_PILOT: begin
            if (!lockIntlkOk) begin
               fault = 1'b1;
            end
            if (selfCheckFail) begin
               fault = 1'b1;
            end
            if (el >= bss_pkg::PILOT_S) begin
               if (flamePresent) begin
                  next_state     = bss_pkg::BSS_MAIN;
                  next_phaseBase = tk.seconds;
               end else begin
                  fault = 1'b1;
               end
            end
         end
         bss_pkg::BSS_MAIN: begin
            if (!lockIntlkOk || selfCheckFail) begin
               fault = 1'b1;
            end
            if (el >= mainLen) begin
               if (flamePresent) begin
                  next_state = bss_pkg::BSS_RUN;
               end else begin
                  fault = 1'b1;
               end
            end
         end
         bss_pkg::BSS_RUN: begin
            tk.hold = 1'b1;
            if (!lockIntlkOk) begin
               fault = 1'b1;
            end
            if (selfCheckFail) begin
               fault = 1'b1;
            end
            if (flameLost) begin
               fault = 1'b1;
            end
            if (!startReq && !fault) begin
               next_state     = bss_pkg::BSS_POST;
               next_phaseBase = tk.seconds;
            end
         end
         bss_pkg::BSS_POST: begin
            if (el >= POSTPURGE_S || tk.seconds >= CYCLE_S) begin
               next_state = bss_pkg::BSS_STANDBY;
            end
         end
         bss_pkg::BSS_LOCKOUT: begin
            tk.clear = 1'b1;
            if (manualReset) begin
               next_state = bss_pkg::BSS_STANDBY;
            end
         end
         default: begin
            next_state = bss_pkg::BSS_LOCKOUT;
         end
      endcase
      if (fault) begin
         next_state = bss_pkg::BSS_LOCKOUT;
      end
   end

   // ---------------------------------------------------------------
   // Outputs, registered from next state
   // ---------------------------------------------------------------
   always_comb begin
      next_blower       = 1'b0;
      next_ignition     = 1'b0;
      next_pilotValve   = 1'b0;
      next_mainValve    = 1'b0;
      next_fireHigh     = 1'b0;
      next_fireLow      = 1'b1;
      next_fireModulate = 1'b0;
      next_alarm        = 1'b0;
      next_lockedOut    = 1'b0;
      case (next_state)
         bss_pkg::BSS_STANDBY: begin
            next_fireLow = 1'b1;
         end
         bss_pkg::BSS_PURGE: begin
            next_blower = 1'b1;
            // Drive open until five seconds before the low fire proving point
            next_fireHigh = (tk.seconds < lofireAt - 8'h05);
            next_fireLow  = !next_fireHigh;
         end
         bss_pkg::BSS_PILOT: begin
            next_blower     = 1'b1;
            next_pilotValve = 1'b1;
            next_ignition   = sparkOn;
         end
         bss_pkg::BSS_MAIN: begin
            next_blower     = 1'b1;
            next_pilotValve = 1'b1;
            next_mainValve  = 1'b1;
            // Early spark keeps the spark off once the pilot is proven
            next_ignition   = !EARLY_SPARK;
         end
         bss_pkg::BSS_RUN: begin
            next_blower       = 1'b1;
            next_mainValve    = 1'b1;
            next_fireLow      = 1'b0;
            next_fireModulate = 1'b1;
         end
         bss_pkg::BSS_POST: begin
            next_blower = 1'b1;
         end
         bss_pkg::BSS_LOCKOUT: begin
            next_alarm     = 1'b1;
            next_lockedOut = 1'b1;
         end
         default: begin
            next_fireLow = 1'b1;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state        <= bss_pkg::BSS_STANDBY;
         phaseBase    <= 8'h00;
         blower       <= 1'b0;
         ignition     <= 1'b0;
         pilotValve   <= 1'b0;
         mainValve    <= 1'b0;
         fireHigh     <= 1'b0;
         fireLow      <= 1'b1;
         fireModulate <= 1'b0;
         alarm        <= 1'b0;
         lockedOut    <= 1'b0;
         seconds      <= 8'h00;
      end else begin
         state        <= next_state;
         phaseBase    <= next_phaseBase;
         blower       <= next_blower;
         ignition     <= next_ignition;
         pilotValve   <= next_pilotValve;
         mainValve    <= next_mainValve;
         fireHigh     <= next_fireHigh;
         fireLow      <= next_fireLow;
         fireModulate <= next_fireModulate;
         alarm        <= next_alarm;
         lockedOut    <= next_lockedOut;
         seconds      <= tk.seconds;
      end
   end
endmodule // bss_sequencer

// *** tb/bss_seq_props.sv ***
// Concurrent checks on the burner safeguard sequencer ports
`timescale 1ns/10ps
module bss_seq_props #(
   parameter int unsigned TICK_CYCLES = 4
) (
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       rst_n,
   // Inputs watched
   input wire logic       manualReset,
   input wire logic       preIgnOk,
   input wire logic       lockIntlkOk,
   input wire logic       highFireOk,
   input wire logic       lowFireOk,
   input wire logic       flamePresent,
   // Outputs watched
   input wire logic       blower,
   input wire logic       ignition,
   input wire logic       pilotValve,
   input wire logic       mainValve,
   input wire logic       fireHigh,
   input wire logic       fireModulate,
   input wire logic       alarm,
   input wire logic       lockedOut,
   input wire logic [7:0] seconds
);
   localparam int FFRT_MAX = 4 * TICK_CYCLES + 2;
   int lossCnt;
   int next_lossCnt;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // Main valve open without flame, counted in clock cycles
   always_comb next_lossCnt = (mainValve && !flamePresent) ? lossCnt + 1 : 0;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) lossCnt <= 0;
      else lossCnt <= next_lossCnt;
   end

   chk_start_refused: assert property (
      (!blower && !preIgnOk)[*2] |=> !blower) else $error("start taken");
   chk_hifire_hold: assert property (
      (seconds == 8'h0a && !highFireOk)[*2] |=> seconds == 8'h0a)
      else $error("timer ran past high fire hold");
   chk_lofire_hold: assert property (
      (seconds == 8'h33 && !lowFireOk)[*2] |=> seconds == 8'h33)
      else $error("timer ran past low fire hold");
   chk_fuel_lockout: assert property (
      lockedOut |-> !(mainValve || pilotValve || ignition))
      else $error("fuel or spark on in lockout");
   chk_alarm_lock: assert property (
      alarm == lockedOut) else $error("alarm differs from lockout");
   chk_lock_zero: assert property (
      lockedOut[*3] |-> seconds == 8'h00) else $error("timer not zero");
   chk_lock_latched: assert property (
      lockedOut && !manualReset && !$past(manualReset) |=> lockedOut)
      else $error("lockout left without reset");
   chk_purge_nofuel: assert property (
      fireHigh |-> !(ignition || pilotValve || mainValve))
      else $error("fuel during high fire purge");
   chk_run_intlk: assert property (
      fireModulate && !lockIntlkOk |-> ##[1:3] !mainValve)
      else $error("main valve held after interlock open");
   chk_flame_loss: assert property (
      lossCnt <= FFRT_MAX) else $error("flame loss response too slow");

   cover property ($rose(fireModulate));
   cover property ($rose(lockedOut));
   cover property (seconds == 8'h0a && !highFireOk);
endmodule // bss_seq_props

// *** tb/bss_flame_model.sv ***
// Flame amplifier and detector model facing the sequencer
`timescale 1ns/10ps
module bss_flame_model (
   // Clock
   input wire logic core_clk,
   // Valve drive seen by the flame
   input wire logic pilotValve,
   input wire logic mainValve,
   // Bench controls
   input wire logic lightOk,
   input wire logic fakeFlame,
   input wire logic detFail,
   // Amplifier outputs
   output logic     flamePresent,
   output logic     selfCheckFail
);
   // Lands just after the edge so the sequencer never races it
   always @(posedge core_clk) begin
      flamePresent <= #1 fakeFlame || (lightOk && (pilotValve || mainValve));
      selfCheckFail <= #1 detFail;
   end
endmodule // bss_flame_model

// *** tb/tb_top.sv ***
// Self-checking bench for the burner safeguard sequencer
`timescale 1ns/10ps
module tb_top;
   localparam int TK = 4;
   logic       core_clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       startReq = 1'b0, manualReset = 1'b0, preIgnOk = 1'b0;
   logic       lockIntlkOk = 1'b1, highFireOk = 1'b1, lowFireOk = 1'b1;
   logic       lightOk = 1'b1, fakeFlame = 1'b0, detFail = 1'b0;
   logic       directSpark = 1'b0, flamePresent, selfCheckFail;
   logic [1:0] mainSel = 2'h1;
   logic       blower, ignition, pilotValve, mainValve, fireHigh, fireLow;
   logic       fireModulate, alarm, lockedOut;
   logic [7:0] seconds;
   int         mismatches = 0, totalChecks = 0, n;

   always #50 core_clk = ~core_clk;

   bss_sequencer #(.TICK_CYCLES(TK)) uut (
      .core_clk(core_clk), .rst_n(rst_n), .startReq(startReq),
      .manualReset(manualReset), .preIgnOk(preIgnOk),
      .lockIntlkOk(lockIntlkOk), .highFireOk(highFireOk),
      .lowFireOk(lowFireOk), .flamePresent(flamePresent),
      .selfCheckFail(selfCheckFail), .mainSel(mainSel),
      .directSpark(directSpark), .blower(blower), .ignition(ignition),
      .pilotValve(pilotValve), .mainValve(mainValve), .fireHigh(fireHigh),
      .fireLow(fireLow), .fireModulate(fireModulate), .alarm(alarm),
      .lockedOut(lockedOut), .seconds(seconds));

   bss_flame_model flame (
      .core_clk(core_clk), .pilotValve(pilotValve), .mainValve(mainValve),
      .lightOk(lightOk), .fakeFlame(fakeFlame), .detFail(detFail),
      .flamePresent(flamePresent), .selfCheckFail(selfCheckFail));

   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      totalChecks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic conclude;
      if (mismatches == 0 && totalChecks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic tk(input int c);
      repeat (c) @(negedge core_clk);
   endtask

   // Lockout is judged, then released by hand with safe inputs
   task automatic clearLock;
      wait (lockedOut === 1'b1);
      @(negedge core_clk);
      startReq = 1'b0;
      tk(10);
      cmp({lockedOut, alarm}, 8'h03);
      cmp({ignition, pilotValve, mainValve}, 8'h00);
      cmp(seconds, 8'h00);
      lightOk = 1'b1;
      fakeFlame = 1'b0;
      detFail = 1'b0;
      lockIntlkOk = 1'b1;
      preIgnOk = 1'b1;
      tk(2);
      manualReset = 1'b1;
      tk(1);
      manualReset = 1'b0;
      tk(2);
      cmp(lockedOut, 1'b0);
   endtask

   // Start to run; n ends as the main flame period in cycles
   task automatic runToRun(input logic [1:0] sel, input logic ds,
                           input logic prove);
      mainSel = sel;
      directSpark = ds;
      highFireOk = !prove;
      lowFireOk = !prove;
      startReq = 1'b1;
      tk(2);
      cmp({blower, fireHigh}, 8'h03);
      if (prove) begin
         wait (seconds === 8'h0a);
         tk(8 * TK);
         cmp(seconds, 8'h0a);
         highFireOk = 1'b1;
         wait (seconds === 8'h33);
         tk(8 * TK);
         cmp(seconds, 8'h33);
         cmp(fireLow, 1'b1);
         lowFireOk = 1'b1;
      end
      wait (mainValve === 1'b1);
      n = 0;
      while (fireModulate !== 1'b1) begin
         @(negedge core_clk);
         n++;
      end
   endtask

   initial begin
      tk(10);
      rst_n = 1'b1;
      startReq = 1'b1;
      tk(6);
      cmp(blower, 1'b0);
      preIgnOk = 1'b1;
      runToRun(2'h1, 1'b0, 1'b1);
      cmp(n >= 14 * TK && n <= 16 * TK, 1'b1);
      lightOk = 1'b0;
      n = 0;
      while (mainValve !== 1'b0) begin
         @(negedge core_clk);
         n++;
      end
      cmp(n >= 2 * TK - 1 && n <= 4 * TK + 2, 1'b1);
      clearLock;
      runToRun(2'h1, 1'b1, 1'b0);
      cmp(n >= 9 * TK && n <= 11 * TK, 1'b1);
      lockIntlkOk = 1'b0;
      tk(3);
      cmp(mainValve, 1'b0);
      clearLock;
      runToRun(2'h2, 1'b0, 1'b0);
      cmp(n >= 14 * TK && n <= 16 * TK, 1'b1);
      detFail = 1'b1;
      clearLock;
      startReq = 1'b1;
      tk(5 * TK);
      fakeFlame = 1'b1;
      clearLock;
      fakeFlame = 1'b1;
      tk(2);
      startReq = 1'b1;
      clearLock;
      startReq = 1'b1;
      tk(20 * TK);
      preIgnOk = 1'b0;
      clearLock;
      startReq = 1'b1;
      lightOk = 1'b0;
      clearLock;
      startReq = 1'b1;
      lockIntlkOk = 1'b0;
      clearLock;
      conclude;
   end

   // Whole run needs under two thousand cycles; fifteen times that is ample
   initial begin
      #3000000;
      mismatches++;
      conclude;
   end
endmodule // tb_top

bind bss_sequencer bss_seq_props #(.TICK_CYCLES(TICK_CYCLES)) chk (
   .core_clk(core_clk), .rst_n(rst_n), .manualReset(manualReset),
   .preIgnOk(preIgnOk), .lockIntlkOk(lockIntlkOk),
   .highFireOk(highFireOk), .lowFireOk(lowFireOk),
   .flamePresent(flamePresent), .blower(blower), .ignition(ignition),
   .pilotValve(pilotValve), .mainValve(mainValve), .fireHigh(fireHigh),
   .fireModulate(fireModulate), .alarm(alarm), .lockedOut(lockedOut),
   .seconds(seconds));
